/* timer_channel.sv */
// What this block does
// - on expiry reload counter from latches; flag set unless measuring with sense zero
// - dual mode: low byte zero holds high; next clock reloads low, high-1
// - dual continuous: output low until high byte zero, then high
// - dual continuous: output high until both zero; expiry drives it low
// - dual with low reload zero: expiry every M+1 clocks, continuous output toggles
// - both reloads zero: counter holds, continuous output toggles every clock
// - counting and flags independent of output enable; counter always readable
// - single-shot: output low after first expiry until reinitialised
// - single-shot: every expiry still flags and reloads
// - single-shot: counting ignores the gate level
// - single-shot zero reload: output low, expiry every clock
// - measure mode: qualifier picks period or low time, sense picks direction
// - measure mode: output low until first expiry, then toggles each expiry
// - measure mode counts 16-bit or dual 8-bit per dual select
// - period, sense one: expiry before gate fall flags and stops counter
// - period, sense zero: gate fall before expiry flags
// - period, sense zero: expiry first blocks flags; next gate fall restarts
// - gate fall enables counter until flag, latch write or timer reset
// - initialisation copies latches to counter and clears the flag
// - continuous mode counts only with gate low and no timer reset
// - pulse-width compare like period but gate rise ends count
module timer_channel
   import timer_chan_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // axi4-lite write address and data
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [3:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // timer pins
   input wire logic GATE_N,
   output logic TIMER_OUTPUT_PIN,
   output logic IRQ_FLAG
);

   // ************************************************
   // register bus
   // ************************************************
   logic [7:0] ctrl_r;
   logic [15:0] latch_r;
   logic aw_held_r, w_held_r;
   logic [3:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic bvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rvalid_r;
   logic wr_go, rd_go, latch_wr, flag_clr;
   ctrl_t c;

   // strobe-wise merge of a byte lane
   function automatic logic [7:0] lane(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic en);
      return en ? nw : old;
   endfunction

   assign c = '{out_en: ctrl_r[OUT_EN_BIT], sense: ctrl_r[SENSE_BIT],
                qual: ctrl_r[QUAL_BIT], measure: ctrl_r[MEASURE_BIT],
                dual: ctrl_r[DUAL_BIT], sw_reset: ctrl_r[SW_RESET_BIT]};

   // each channel held until both halves are in and no response pends
   assign AWREADY = !aw_held_r;
   assign WREADY = !w_held_r;
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;
   assign ARREADY = !rvalid_r;
   assign rd_go = ARVALID && !rvalid_r;
   assign latch_wr = wr_go && awaddr_r[3:2] == LATCH_OFS[3:2]
                     && |wstrb_r[1:0];
   assign flag_clr = wr_go && awaddr_r[3:2] == STATUS_OFS[3:2]
                     && wstrb_r[0] && wdata_r[0];
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;

   // address and data capture, either order
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_held_r <= 1'b1;
            awaddr_r <= AWADDR;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_held_r <= 1'b1;
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= RESP_OKAY;
      end else if (BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_r <= CTRL_RST;
         latch_r <= LATCH_RST;
      end else if (wr_go) begin
         if (awaddr_r[3:2] == CTRL_OFS[3:2])
            ctrl_r <= lane(ctrl_r, wdata_r[7:0], wstrb_r[0]);
         if (awaddr_r[3:2] == LATCH_OFS[3:2]) begin
            latch_r[7:0] <= lane(latch_r[7:0], wdata_r[7:0], wstrb_r[0]);
            latch_r[15:8] <= lane(latch_r[15:8], wdata_r[15:8], wstrb_r[1]);
         end
      end
   end

   // ************************************************
   // counter core
   // ************************************************
   logic [15:0] cnt_r;
   logic flag_r, out_r, gate_q_r, ce_r, block_r, shot_done_r;
   logic [2:0] mode_q_r;
   logic g_fall, g_rise, zero, expiry, init, cnt_en, flag_set, w_init;
   logic zero_reload, hi_zero;

   assign g_fall = gate_q_r && !GATE_N;
   assign g_rise = !gate_q_r && GATE_N;
   assign zero = cnt_r == 16'h0;
   assign expiry = zero && cnt_en;
   assign hi_zero = cnt_r[15:8] == 8'h0;
   assign zero_reload = latch_r == 16'h0;
   // latch write initialises only with qualifier clear in synthesis modes
   assign w_init = latch_wr && !c.qual && !c.measure;

   // initialisation sources per mode
   always_comb begin
      init = c.sw_reset || w_init;
      if (c.measure) begin
         if (!c.qual && !c.sense)
            init = init || (g_fall && !flag_r && (!ce_r || block_r));
         else
            init = init || (g_fall && !flag_r);
      end else begin
         init = init || g_fall;
      end
   end

   // counter enable per mode
   always_comb begin
      if (c.sw_reset)
         cnt_en = 1'b0;
      else if (c.measure)
         cnt_en = ce_r;
      else if (c.sense)
         cnt_en = 1'b1;
      else
         cnt_en = !GATE_N;
   end

   // flag causes: expiry in synthesis, compare outcome in measurement
   always_comb begin
      flag_set = 1'b0;
      if (!c.measure)
         flag_set = expiry;
      else if (c.sense)
         flag_set = expiry && ce_r;
      else if (!c.qual)
         flag_set = g_fall && ce_r && !block_r;
      else
         flag_set = g_rise && ce_r && !block_r;
   end

   // gate edge history
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         gate_q_r <= 1'b1;
      else
         gate_q_r <= GATE_N;
   end

   // down counter
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_r <= LATCH_RST;
      end else if (init || expiry) begin
         cnt_r <= latch_r;
      end else if (cnt_en) begin
         if (c.dual) begin
            if (cnt_r[7:0] == 8'h0) begin
               cnt_r[7:0] <= latch_r[7:0];
               cnt_r[15:8] <= cnt_r[15:8] - 8'h1;
            end else begin
               cnt_r[7:0] <= cnt_r[7:0] - 8'h1;
            end
         end else begin
            cnt_r <= cnt_r - 16'h1;
         end
      end
   end

   // interrupt flag, set wins over software clear
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         flag_r <= 1'b0;
      else if (flag_set)
         flag_r <= 1'b1;
      else if (init || flag_clr)
         flag_r <= 1'b0;
   end

   // measurement enable flip-flop and expiry block bit
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         ce_r <= 1'b0;
         block_r <= 1'b0;
      end else begin
         if (latch_wr || c.sw_reset || flag_set)
            ce_r <= 1'b0;
         else if (c.measure && c.qual && GATE_N && ce_r)
            ce_r <= 1'b0;
         else if (init && c.measure && g_fall)
            ce_r <= 1'b1;
         if (init)
            block_r <= 1'b0;
         else if (expiry && c.measure && !c.sense)
            block_r <= 1'b1;
      end
   end

   // ************************************************
   // output waveform
   // ************************************************
   // mode change reopens a finished single shot
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         mode_q_r <= 3'h0;
      else
         mode_q_r <= {c.measure, c.qual, c.sense};
   end

   // waveform per mode; every initialisation restarts it low
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         out_r <= 1'b0;
         shot_done_r <= 1'b0;
      end else if (init) begin
         out_r <= 1'b0;
         shot_done_r <= 1'b0;
      end else if (!c.measure && c.sense && (shot_done_r || zero_reload)) begin
         out_r <= 1'b0;
         if (mode_q_r != {c.measure, c.qual, c.sense})
            shot_done_r <= 1'b0;
      end else if (c.measure) begin
         if (expiry)
            out_r <= !out_r;
      end else if (c.dual && latch_r[7:0] != 8'h0) begin
         if (expiry) begin
            out_r <= 1'b0;
            shot_done_r <= c.sense;
         end else if (cnt_en && hi_zero)
            out_r <= 1'b1;
      end else if (c.dual) begin
         // zero low reload: single shot ends on its first expiry
         if (expiry) begin
            out_r <= c.sense ? 1'b0 : !out_r;
            shot_done_r <= c.sense;
         end else if (c.sense && cnt_en) begin
            out_r <= 1'b1;
         end
      end else begin
         // 16-bit: continuous toggles, single shot pulses once
         if (expiry) begin
            out_r <= c.sense ? 1'b0 : !out_r;
            shot_done_r <= c.sense;
         end else if (c.sense && cnt_en) begin
            out_r <= 1'b1;
         end
      end
   end

   assign TIMER_OUTPUT_PIN = out_r && c.out_en;
   assign IRQ_FLAG = flag_r;

   // ************************************************
   // register reads
   // ************************************************
   // read data registered, so it stands until rready is seen
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= RESP_OKAY;
         unique case (ARADDR[3:2])
            CTRL_OFS[3:2]: rdata_r <= {24'h0, ctrl_r};
            LATCH_OFS[3:2]: rdata_r <= {16'h0, latch_r};
            COUNT_OFS[3:2]: rdata_r <= {16'h0, cnt_r};
            STATUS_OFS[3:2]: rdata_r <= {29'h0, out_r, ce_r, flag_r};
         endcase
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

/* timer_chan_pkg.sv */
package timer_chan_pkg;
   // ************************************************
   // register map (byte addresses)
   // ************************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] LATCH_OFS = 4'h4;
   localparam logic [3:0] COUNT_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hc;

   // control field positions
   localparam int SW_RESET_BIT = 0;
   localparam int DUAL_BIT = 2;
   localparam int MEASURE_BIT = 3;
   localparam int QUAL_BIT = 4;
   localparam int SENSE_BIT = 5;
   localparam int OUT_EN_BIT = 7;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [15:0] LATCH_RST = 16'hffff;

   // axi4-lite responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // decoded control word
   typedef struct packed {
      logic out_en;
      logic sense;
      logic qual;
      logic measure;
      logic dual;
      logic sw_reset;
   } ctrl_t;
endpackage

/* timer_channel_chk.sv */
// ****
// bus and pin checks
// ****
module timer_channel_chk
   import timer_chan_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // bus
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   // timer pins
   input wire logic TIMER_OUTPUT_PIN,
   input wire logic IRQ_FLAG
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   logic oen_r, sw_r;
   // control shadow leads the design, so checks look a few cycles back
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         oen_r <= 1'b0;
         sw_r <= 1'b1;
      end else if (AWVALID && AWREADY && WVALID && WREADY &&
                   AWADDR[3:2] == CTRL_OFS[3:2]) begin
         oen_r <= WDATA[OUT_EN_BIT];
         sw_r <= WDATA[SW_RESET_BIT];
      end
   end
   property p_b_ans;
      AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID;
   endproperty
   a_b_ans: assert property (p_b_ans) else $error("no write answer");
   property p_b_drop;
      BVALID && BREADY |=> !BVALID;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
   property p_b_okay;
      BVALID |-> BRESP == RESP_OKAY;
   endproperty
   a_b_okay: assert property (p_b_okay) else $error("bad bresp");
   property p_r_ans;
      ARVALID && ARREADY |=> RVALID;
   endproperty
   a_r_ans: assert property (p_r_ans) else $error("no read answer");
   property p_r_busy;
      RVALID |-> !ARREADY;
   endproperty
   a_r_busy: assert property (p_r_busy) else $error("read overlap");
   property p_oen;
      !oen_r && !$past(oen_r, 2) |-> !TIMER_OUTPUT_PIN;
   endproperty
   a_oen: assert property (p_oen) else $error("pin not masked");
   property p_init_flag;
      sw_r && $past(sw_r, 3) |-> !IRQ_FLAG;
   endproperty
   a_init_flag: assert property (p_init_flag) else $error("flag in reset");
   property p_init_pin;
      sw_r && $past(sw_r, 3) |-> !TIMER_OUTPUT_PIN;
   endproperty
   a_init_pin: assert property (p_init_pin) else $error("pin in reset");
endmodule
bind timer_channel timer_channel_chk timer_channel_chk_inst (
   .REF_CLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WVALID,
   .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID,
   .TIMER_OUTPUT_PIN, .IRQ_FLAG);

/* host_model.sv */
// ****
// bus master on the host side
// ****
module host_model (
   // clock
   input wire logic REF_CLK,
   // write side
   output logic [3:0] AWADDR,
   output logic AWVALID,
   input wire logic AWREADY,
   output logic [31:0] WDATA,
   output logic [3:0] WSTRB,
   output logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   output logic BREADY,
   // read side
   output logic [3:0] ARADDR,
   output logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   output logic RREADY
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {AWADDR, ARADDR, WSTRB, WDATA} = '0;
   end
   // released lines flip so stale payload never looks valid
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic done;
      done = 0;
      @(posedge REF_CLK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= d;
      WSTRB <= 4'hf;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!done) begin
         @(posedge REF_CLK);
         if (AWVALID && AWREADY) begin
            AWVALID <= 1'b0;
            AWADDR <= ~a;
         end
         if (WVALID && WREADY) begin
            WVALID <= 1'b0;
            WDATA <= ~d;
         end
         if (BVALID) begin
            BREADY <= 1'b0;
            done = 1;
         end
      end
   endtask
   // read waits for rvalid, no latency assumed
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      logic done;
      done = 0;
      @(posedge REF_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!done) begin
         @(posedge REF_CLK);
         if (ARVALID && ARREADY) begin
            ARVALID <= 1'b0;
            ARADDR <= ~a;
         end
         if (RVALID) begin
            d = RDATA;
            RREADY <= 1'b0;
            done = 1;
         end
      end
   endtask
endmodule

/* timer_channel_tb.sv */
// ****
// channel testbench
// ****
module timer_channel_tb
   import timer_chan_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic REF_CLK = 0, NRST = 0, GATE_N = 1;
   logic [3:0] AWADDR, WSTRB, ARADDR;
   logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY, TIMER_OUTPUT_PIN, IRQ_FLAG;
   logic [31:0] WDATA, RDATA, v;
   logic [1:0] BRESP, RRESP;
   logic p;
   int miscompares = 0, n_tests = 0;
   typedef struct packed {
      logic [7:0] c;
      logic [15:0] l;
      logic g;
      logic f;
   } row_t;
   // mode, latch, gate level, flag after 40 clocks
   row_t rows [6] = '{
      '{8'h80, 16'h0003, 1'b0, 1'b1},
      '{8'h80, 16'h0003, 1'b1, 1'b0},
      '{8'ha0, 16'h0003, 1'b1, 1'b1},
      '{8'h84, 16'h0101, 1'b0, 1'b1},
      '{8'h00, 16'h0003, 1'b0, 1'b1},
      '{8'h88, 16'h0003, 1'b0, 1'b0}};
   timer_channel timer_channel_inst (.REF_CLK, .NRST, .AWADDR, .AWVALID,
      .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
      .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
      .GATE_N, .TIMER_OUTPUT_PIN, .IRQ_FLAG);
   host_model host_model_inst (.REF_CLK, .AWADDR, .AWVALID, .AWREADY,
      .WDATA, .WSTRB, .WVALID, .WREADY, .BVALID, .BREADY, .ARADDR,
      .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY);
   always #5 REF_CLK = ~REF_CLK;
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge REF_CLK);
   endtask
   // load latch under timer reset, so the counter must mirror it
   task automatic setup(logic [7:0] c, logic [15:0] l, logic g);
      host_model_inst.wr(CTRL_OFS, 32'h1);
      host_model_inst.wr(LATCH_OFS, {16'h0, l});
      host_model_inst.rd(COUNT_OFS, v);
      chk("count", v, {16'h0, l});
      chk("rresp", RRESP, RESP_OKAY);
      chk("flag", IRQ_FLAG, 0);
      GATE_N <= g;
      host_model_inst.wr(CTRL_OFS, {24'h0, c});
   endtask
   // watchdog well past the expected several hundred clocks
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
   initial begin
      cyc(12);
      NRST <= 1'b1;
      host_model_inst.rd(CTRL_OFS, v);
      chk("ctrl", v, {24'h0, CTRL_RST});
      host_model_inst.rd(LATCH_OFS, v);
      chk("latch", v, {16'h0, LATCH_RST});
      foreach (rows[i]) begin
         setup(rows[i].c, rows[i].l, rows[i].g);
         cyc(40);
         chk("flag", IRQ_FLAG, rows[i].f);
         host_model_inst.rd(STATUS_OFS, v);
         chk("status", v[0], rows[i].f);
      end
      // expiry before gate fall stops the counter
      setup(8'ha8, 16'h0005, 1'b1);
      cyc(3);
      GATE_N <= 1'b0;
      cyc(30);
      chk("flag", IRQ_FLAG, 1);
      host_model_inst.rd(STATUS_OFS, v);
      chk("enable", v[1], 0);
      host_model_inst.wr(STATUS_OFS, 32'h1);
      cyc(20);
      chk("flag", IRQ_FLAG, 0);
      // short gate period, then short low pulse
      for (int k = 0; k < 2; k++) begin
         setup(k ? 8'h98 : 8'h88, 16'h0064, 1'b1);
         cyc(3);
         GATE_N <= 1'b0;
         cyc(5);
         GATE_N <= 1'b1;
         cyc(5);
         GATE_N <= k[0];
         cyc(3);
         chk("flag", IRQ_FLAG, 1);
      end
      // expiry first blocks the flag; the next gate fall restarts
      setup(8'h88, 16'h0005, 1'b1);
      cyc(3);
      GATE_N <= 1'b0;
      cyc(20);
      GATE_N <= 1'b1;
      cyc(3);
      GATE_N <= 1'b0;
      cyc(2);
      chk("flag", IRQ_FLAG, 0);
      GATE_N <= 1'b1;
      cyc(1);
      GATE_N <= 1'b0;
      cyc(2);
      chk("flag", IRQ_FLAG, 1);
      // zero reloads toggle every clock; masked pin stays low
      setup(8'h84, 16'h0000, 1'b0);
      cyc(5);
      p = TIMER_OUTPUT_PIN;
      cyc(1);
      chk("pin", TIMER_OUTPUT_PIN, {31'h0, ~p});
      host_model_inst.wr(CTRL_OFS, 32'h04);
      cyc(4);
      chk("pin", TIMER_OUTPUT_PIN, 0);
      // single shot with zero reload keeps the pin low
      setup(8'ha4, 16'h0000, 1'b1);
      cyc(6);
      chk("pin", TIMER_OUTPUT_PIN, 0);
      chk("flag", IRQ_FLAG, 1);
      // single shot: one pulse, then low while expiries go on
      setup(8'ha0, 16'h0003, 1'b1);
      cyc(1);
      chk("pin", TIMER_OUTPUT_PIN, 1);
      cyc(12);
      chk("pin", TIMER_OUTPUT_PIN, 0);
      chk("flag", IRQ_FLAG, 1);
      wrap_up();
   end
endmodule
